// file: rtl/piso_shifter.sv
// Eight-stage parallel-in serial-out shift register with gated clock
// Notes on behaviour
// - Enabled shift edge with load high moves stages toward last, serial in first.
// - Falling edge of load copies parallel inputs, ignoring clock, inhibit, serial.
// - While load is low, each stage follows its parallel input directly.
// - Internal shift clock is NOR of both clock inputs; either high blocks.
// - With one clock input low, rising edges on the other shift.
// - Parallel inputs are ignored entirely while load stays high.
// - Last stage drives a true serial output and its inverse.
// - Load high without an enabled edge holds every stage unchanged.
`timescale 1ns/1ps
module piso_shifter (
	input  wire logic                              core_clk,
	input  wire logic                              rst,
	input  wire logic [piso_pkg::STAGE_COUNT-1:0]  parallelIn,
	input  wire logic                              serialIn,
	input  wire logic                              clkIn,
	input  wire logic                              clkInhibit,
	input  wire logic                              loadN,
	output logic                                   serialOut,
	output logic                                   serialOutN,
	output logic      [piso_pkg::STAGE_COUNT-1:0]  stageView,
	output logic                                   loading,
	output logic                                   shiftPulse,
	output logic                                   loadPulse,
	output logic                                   contentsKnown
);

	piso_pkg::pins_t                   pinsRaw;
	piso_pkg::pins_t                   pinsSync;
	logic [piso_pkg::PINS_W-1:0]       pinsSyncBits;

	logic [piso_pkg::STAGE_COUNT-1:0]  stage_q;
	logic [piso_pkg::STAGE_COUNT-1:0]  stage_d;
	logic                              clkNor;
	logic                              clkNor_q;
	logic                              shiftEdge;
	logic                              loadFall;
	piso_pkg::mode_t                   mode_q;
	piso_pkg::mode_t                   mode_d;
	logic [piso_pkg::CNT_W-1:0]        shiftCnt_q;
	logic [piso_pkg::CNT_W-1:0]        shiftCnt_d;
	logic                              known_q;
	logic                              known_d;

	assign pinsRaw.parallelIn = parallelIn;
	assign pinsRaw.serialIn   = serialIn;
	assign pinsRaw.clkInhibit = clkInhibit;
	assign pinsRaw.clkIn      = clkIn;
	assign pinsRaw.loadN      = loadN;

	// Every pin is synchronised as one bundle so they keep their alignment
	pin_sync #(
		.WIDTH     (piso_pkg::PINS_W),
		.RESET_VAL (piso_pkg::PINS_RESET)
	) u_pin_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.asyncIn  (pinsRaw),
		.syncOut  (pinsSyncBits)
	);

	assign pinsSync = piso_pkg::pins_t'(pinsSyncBits);

	// Gated clock: a high level on either input holds it low
	assign clkNor = ~(pinsSync.clkIn | pinsSync.clkInhibit);

	// Active edge is the gated clock falling, i.e. the enabled input rising;
	// raising inhibit while the clock is low also makes one, so the host
	// must only raise inhibit with the clock already high
	assign shiftEdge = pinsSync.loadN & clkNor_q & ~clkNor;

	assign loadFall = (mode_q == piso_pkg::MODE_SHIFT) & ~pinsSync.loadN;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			clkNor_q <= piso_pkg::NOR_RESET;
		end else begin
			clkNor_q <= clkNor;
		end
	end

	// Next stage contents
	always_comb begin
		stage_d = stage_q;
		if (!pinsSync.loadN) begin
			// Load low overrides everything, edge or level alike
			stage_d = pinsSync.parallelIn;
		end else if (shiftEdge) begin
			stage_d = {stage_q[piso_pkg::STAGE_COUNT-2:0],
				pinsSync.serialIn};
		end else begin
			stage_d = stage_q;
		end
	end

	// Stages clear on rst only so the outputs are defined in simulation;
	// the hardware makes no promise about them until filled
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stage_q <= piso_pkg::STAGE_RESET;
		end else begin
			stage_q <= stage_d;
		end
	end

	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			piso_pkg::MODE_LOAD: begin
				if (pinsSync.loadN) begin
					mode_d = piso_pkg::MODE_SHIFT;
				end
			end
			piso_pkg::MODE_SHIFT: begin
				if (!pinsSync.loadN) begin
					mode_d = piso_pkg::MODE_LOAD;
				end
			end
			default: begin
				mode_d = piso_pkg::MODE_LOAD;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q <= piso_pkg::MODE_SHIFT;
		end else begin
			mode_q <= mode_d;
		end
	end

	// Contents become known after a load or after eight fresh serial bits
	always_comb begin
		shiftCnt_d = shiftCnt_q;
		known_d    = known_q;
		if (!pinsSync.loadN) begin
			known_d    = 1'b1;
			shiftCnt_d = piso_pkg::CNT_RESET;
		end else if (shiftEdge && !known_q) begin
			shiftCnt_d = shiftCnt_q + 4'h1;
			if (shiftCnt_d == piso_pkg::CNT_FULL) begin
				known_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			shiftCnt_q <= piso_pkg::CNT_RESET;
			known_q    <= 1'b0;
		end else begin
			shiftCnt_q <= shiftCnt_d;
			known_q    <= known_d;
		end
	end

	// Outputs are registered from the next value so they line up with stage_q
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			serialOut  <= piso_pkg::STAGE_RESET[piso_pkg::STAGE_COUNT-1];
			serialOutN <= ~piso_pkg::STAGE_RESET[piso_pkg::STAGE_COUNT-1];
			stageView  <= piso_pkg::STAGE_RESET;
		end else begin
			serialOut  <= stage_d[piso_pkg::STAGE_COUNT-1];
			serialOutN <= ~stage_d[piso_pkg::STAGE_COUNT-1];
			stageView  <= stage_d;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			loading       <= 1'b0;
			shiftPulse    <= 1'b0;
			loadPulse     <= 1'b0;
			contentsKnown <= 1'b0;
		end else begin
			loading       <= ~pinsSync.loadN;
			shiftPulse    <= shiftEdge;
			loadPulse     <= loadFall;
			contentsKnown <= known_d;
		end
	end

endmodule

// file: rtl/piso_pkg.sv
// Shared constants and carrier types for the parallel-in serial-out shifter
package piso_pkg;

	localparam int STAGE_COUNT = 8;
	localparam int SYNC_DEPTH  = 2;
	localparam int CNT_W       = 4;

	localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;
	localparam logic [CNT_W-1:0]       CNT_RESET   = 4'h0;
	localparam logic [CNT_W-1:0]       CNT_FULL    = 4'h8;
	localparam logic                   NOR_RESET   = 1'h1;

	// Bundle of every pin that arrives from outside the clock domain
	typedef struct packed {
		logic [STAGE_COUNT-1:0] parallelIn;
		logic                   serialIn;
		logic                   clkInhibit;
		logic                   clkIn;
		logic                   loadN;
	} pins_t;

	localparam int PINS_W = $bits(pins_t);
	localparam logic [PINS_W-1:0] PINS_RESET = 12'h001;

	typedef enum logic [1:0] {
		MODE_LOAD,
		MODE_SHIFT
	} mode_t;

endpackage

// file: rtl/pin_sync.sv
// Two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int                WIDTH     = 1,
	parameter logic [WIDTH-1:0]  RESET_VAL = '0
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] meta_q;

	// The first stage feeds only the second, never any logic
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			meta_q  <= RESET_VAL;
			syncOut <= RESET_VAL;
		end else begin
			meta_q  <= asyncIn;
			syncOut <= meta_q;
		end
	end

endmodule

// file: testbench/piso_shifter_properties.sv
// Pin-level checks on the shifter
`timescale 1ns/1ps
module piso_shifter_properties (
	input wire logic       core_clk,
	input wire logic       rst,
	input wire logic [7:0] parallelIn,
	input wire logic       clkIn,
	input wire logic       clkInhibit,
	input wire logic       loadN,
	input wire logic       serialOut,
	input wire logic       serialOutN,
	input wire logic [7:0] stageView,
	input wire logic       loading,
	input wire logic       shiftPulse,
	input wire logic       loadPulse
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_out_inverse: assert property (serialOutN == !serialOut)
		else $error("complement wrong");
	chk_out_last: assert property (serialOut == stageView[7])
		else $error("serial out not last stage");
	chk_shift_moves: assert property (shiftPulse |->
		stageView[7:1] == $past(stageView[6:0])) else $error("bad shift");
	chk_idle_holds: assert property (!shiftPulse && !loading |->
		$stable(stageView)) else $error("stages moved");
	// Pin sampled, then synchronised, then registered: seen three edges on
	chk_load_edge: assert property ($fell(loadN) |-> ##3 loadPulse)
		else $error("no load pulse");
	chk_load_follow: assert property (loading |->
		stageView == $past(parallelIn, 3)) else $error("not following");
	chk_load_level: assert property (loading == !$past(loadN, 3))
		else $error("loading wrong");
	chk_clock_edge: assert property ($rose(clkIn) && !clkInhibit &&
		loadN |-> ##3 shiftPulse) else $error("edge missed");
	cover property (shiftPulse);
	cover property (loadPulse);
	cover property ($fell(loading));
endmodule
bind piso_shifter piso_shifter_properties u_chk (.core_clk(core_clk),
	.rst(rst), .parallelIn(parallelIn), .clkIn(clkIn),
	.clkInhibit(clkInhibit), .loadN(loadN), .serialOut(serialOut),
	.serialOutN(serialOutN), .stageView(stageView), .loading(loading),
	.shiftPulse(shiftPulse), .loadPulse(loadPulse));

// file: testbench/serial_sink.sv
// Host-side sink gathering the serial stream into a byte
`timescale 1ns/1ps
module serial_sink (
	input  wire logic       core_clk,
	input  wire logic       serialOut,
	input  wire logic       shiftPulse,
	input  wire logic       loadPulse,
	output logic      [7:0] word
);
	// Load shows the last stage first, each shift the next one down
	always_ff @(posedge core_clk) begin
		if (shiftPulse || loadPulse) begin
			word <= {word[6:0], serialOut};
		end
	end
endmodule

// file: testbench/tb_piso_shifter.sv
// Self-checking bench for the shifter
`timescale 1ns/1ps
module tb_piso_shifter;
	logic       core_clk = 0, rst = 1, serialIn = 0, clkIn = 0;
	logic       clkInhibit = 0, loadN = 1, serialOut, serialOutN;
	logic       loading, shiftPulse, loadPulse, contentsKnown;
	logic [7:0] parallelIn = 8'h00, stageView, word;
	int         err_count = 0, checked = 0;
	piso_shifter u_dut (.core_clk(core_clk), .rst(rst),
		.parallelIn(parallelIn), .serialIn(serialIn), .clkIn(clkIn),
		.clkInhibit(clkInhibit), .loadN(loadN), .serialOut(serialOut),
		.serialOutN(serialOutN), .stageView(stageView), .loading(loading),
		.shiftPulse(shiftPulse), .loadPulse(loadPulse),
		.contentsKnown(contentsKnown));
	serial_sink u_sink (.core_clk(core_clk), .serialOut(serialOut),
		.shiftPulse(shiftPulse), .loadPulse(loadPulse), .word(word));
	initial forever #50 core_clk = ~core_clk;
	task automatic wt(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s exp %h seen %h", name, exp, seen);
		end
	endtask
	// Each level held 4 cycles so the synchroniser sees every edge
	task automatic pulse(ref logic pin);
		pin = 1;
		wt(4);
		pin = 0;
		wt(4);
	endtask
	task automatic t_load;
		parallelIn = 8'ha5;
		loadN = 0;
		wt(4);
		check("stage", stageView, 8'ha5);
		check("loading", {7'h0, loading}, 8'h01);
		check("known", {7'h0, contentsKnown}, 8'h01);
		check("outN", {7'h0, serialOutN}, 8'h00);
		parallelIn = 8'h3c;
		wt(4);
		check("follow", stageView, 8'h3c);
		parallelIn = 8'ha5;
		wt(4);
		loadN = 1;
		wt(4);
	endtask
	task automatic t_shift;
		logic [7:0] feed = 8'h96;
		parallelIn = 8'hff;
		for (int i = 7; i >= 0; i--) begin
			if (i == 0) check("sink", word, 8'ha5);
			serialIn = feed[i];
			pulse(clkIn);
		end
		check("shifted", stageView, 8'h96);
	endtask
	task automatic t_inhibit;
		clkIn = 1;
		wt(4);
		check("rise", stageView, 8'h2c);
		clkInhibit = 1;
		wt(4);
		clkIn = 0;
		wt(4);
		pulse(clkIn);
		check("blocked", stageView, 8'h2c);
		clkInhibit = 0;
		serialIn = 1;
		wt(4);
		pulse(clkInhibit);
		check("other", stageView, 8'h59);
	endtask
	// Mid-run reset, then eight serial bits with no load make contents known
	task automatic t_refill;
		logic [7:0] feed = 8'hc3;
		rst = 1;
		wt(2);
		rst = 0;
		wt(4);
		check("known1", {7'h0, contentsKnown}, 8'h00);
		for (int i = 7; i >= 0; i--) begin
			if (i == 0)
				check("known7", {7'h0, contentsKnown}, 8'h00);
			serialIn = feed[i];
			pulse(clkIn);
		end
		check("known8", {7'h0, contentsKnown}, 8'h01);
		check("refill", stageView, 8'hc3);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		wt(6);
		rst = 0;
		wt(3);
		check("known0", {7'h0, contentsKnown}, 8'h00);
		t_load;
		t_shift;
		t_inhibit;
		t_refill;
		end_sim;
	end
	initial begin
		wt(1000);
		err_count++;
		end_sim;
	end
endmodule
